// ==== sim/power_seq_slot_config_tb_top.sv ====
// Testbench for the slot configuration bank: AXI4-Lite tasks and sequencer runs.
// Assumes a 10 MHz core_clk; slot durations are the real ones shortened 160 times.
`timescale 1ns/1ps
module power_seq_slot_config_tb_top;
    localparam int DUR_TB [16] = '{2, 4, 6, 8, 10, 12, 14, 16, 18, 24, 28, 32, 64, 128, 256, 512};
    logic              core_clk, reset_n, s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic              s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
    logic              s_axi_arready, s_axi_rvalid, seq_up_req, seq_down_req, dual_phase_mode;
    logic              seq_idle, pd_group_active, core_buck_a_en, core_buck_b_en;
    logic              processor_buck_en, io_buck_en, memory_buck_en, peripheral_buck_en;
    logic              core_rail_switch_en, peripheral_rail_switch_en;
    logic [11:0]       s_axi_awaddr, s_axi_araddr;
    logic [31:0]       s_axi_wdata, s_axi_rdata, rd, n;
    logic [1:0]        s_axi_bresp, s_axi_rresp, rs;
    logic [3:0]        current_slot_pointer;
    logic [10:0]       linreg_en;
    logic [4:0]        gen_out;
    logic [24:0]       loads;
    logic [24:0][3:0]  rise_slot, fall_slot;
    int                n_mismatch, samples_checked;
    // Timing byte first, then slot bytes; slots 0, 7 and 15 stay unused on purpose
    logic [7:0] bank [16] = '{8'hef, 8'h21, 8'h43, 8'h65, 8'h98, 8'hba, 8'hdc, 8'hee,
                              8'h21, 8'h43, 8'h65, 8'ha1, 8'hb2, 8'hc3, 8'hd4, 8'he5};

    assign loads = {gen_out, peripheral_rail_switch_en, core_rail_switch_en, peripheral_buck_en,
                    memory_buck_en, io_buck_en, processor_buck_en, core_buck_b_en,
                    core_buck_a_en, pd_group_active, linreg_en};

    power_seq_slot_config #(.DUR_CYC(DUR_TB)) dut_u (
        .core_clk, .reset_n, .ce(1'b1), .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'h1), .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot(3'h0),
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .seq_up_req, .seq_down_req, .dual_phase_mode, .seq_idle,
        .current_slot_pointer, .linreg_en, .pd_group_active, .core_buck_a_en, .core_buck_b_en,
        .processor_buck_en, .io_buck_en, .memory_buck_en, .peripheral_buck_en,
        .core_rail_switch_en, .peripheral_rail_switch_en, .gen_out);

    sequencer_load_model load_u (.core_clk, .reset_n, .ptr(current_slot_pointer), .loads,
                                 .rise_slot, .fall_slot);

    function automatic logic [3:0] nib(input int k);
        return k[0] ? bank[1 + k / 2][7:4] : bank[1 + k / 2][3:0];
    endfunction

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wrap_up;
        $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    // Address and data are offered together; each is dropped once its own ready is seen
    task automatic axw(input logic [9:0] idx, input logic [7:0] d, output logic [1:0] r);
        @(posedge core_clk);
        s_axi_awaddr <= {idx, 2'b00};
        s_axi_wdata <= {24'h00_0000, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        forever begin
            @(posedge core_clk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) begin
                r = s_axi_bresp;
                s_axi_bready <= 1'b0;
                break;
            end
        end
    endtask

    task automatic axr(input logic [9:0] idx, output logic [31:0] d, output logic [1:0] r);
        @(posedge core_clk);
        s_axi_araddr <= {idx, 2'b00};
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        forever begin
            @(posedge core_clk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) begin
                d = s_axi_rdata;
                r = s_axi_rresp;
                s_axi_rready <= 1'b0;
                break;
            end
        end
    endtask

    task automatic start(input logic up);
        @(posedge core_clk);
        if (up) seq_up_req <= 1'b1;
        else seq_down_req <= 1'b1;
        do @(posedge core_clk); while (seq_idle !== 1'b0);
        seq_up_req <= 1'b0;
        seq_down_req <= 1'b0;
    endtask

    task automatic wait_idle;
        do @(posedge core_clk); while (seq_idle !== 1'b1);
    endtask

    // Counts the edges at which the pointer sits in slot s
    task automatic measure(input logic [3:0] s, output logic [31:0] cnt);
        while (current_slot_pointer !== s) @(posedge core_clk);
        cnt = 0;
        while (current_slot_pointer === s) begin
            cnt++;
            @(posedge core_clk);
        end
    endtask

    initial begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end

    initial begin
        repeat (50000) @(posedge core_clk);
        n_mismatch++;
        wrap_up();
    end

    initial begin
        {reset_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        {seq_up_req, seq_down_req, dual_phase_mode, s_axi_awaddr, s_axi_araddr} = '0;
        s_axi_wdata = '0;
        repeat (8) @(posedge core_clk);
        reset_n <= 1'b1;
        for (int i = 0; i < 16; i++) begin
            axr(10'h082 + 10'(i), rd, rs);
            chk(rd, 32'h0000_0000);
            axw(10'h082 + 10'(i), bank[i], rs);
            chk(rs, power_seq_pkg::RESP_OKAY);
            axr(10'h082 + 10'(i), rd, rs);
            chk(rd, {24'h00_0000, bank[i]});
        end
        axw(10'h3ff, 8'h5a, rs);
        chk(rs, power_seq_pkg::RESP_SLVERR);
        axr(10'h3ff, rd, rs);
        chk(rs, power_seq_pkg::RESP_SLVERR);
        chk(rd, 32'h0000_0000);
        axw(power_seq_pkg::SEQ_CTRL_IDX, 8'h0f, rs);
        axr(power_seq_pkg::SEQ_CTRL_IDX, rd, rs);
        chk(rd, 32'h0000_0000);
        $display("test registers done");
        dual_phase_mode <= 1'b1;
        start(1'b1);
        measure(4'h6, n);
        chk(n, 32'(1 + DUR_TB[bank[0][3:0]]));
        measure(4'h7, n);
        chk(n, 32'(1 + DUR_TB[bank[0][7:4]]));
        wait_idle();
        for (int b = 0; b < 20; b++) if (b != 13) chk(rise_slot[b], nib(b));
        for (int g = 0; g < 5; g++) chk({rise_slot[20 + g], fall_slot[20 + g]},
                                        {nib(20 + 2 * g), nib(21 + 2 * g)});
        chk(core_buck_b_en, 1'b0);
        $display("test power-up done");
        dual_phase_mode <= 1'b0;
        start(1'b0);
        wait_idle();
        for (int b = 0; b < 20; b++) if (b != 13) chk(fall_slot[b], nib(b));
        chk({current_slot_pointer, loads}, {4'h0, 5'h1f, 20'h0_0000});
        $display("test power-down done");
        axw(power_seq_pkg::SLOT_TIMING_CODES_IDX, 8'h34, rs);
        axw(power_seq_pkg::SEQ_CTRL_IDX, 8'h60, rs);
        axr(power_seq_pkg::SEQ_CTRL_IDX, rd, rs);
        chk(rd, 32'h0000_0060);
        start(1'b1);
        measure(4'h6, n);
        chk(n, 32'(1 + DUR_TB[4]));
        measure(4'h7, n);
        chk(n, 32'(1 + DUR_TB[3]));
        wait_idle();
        for (int b = 0; b < 20; b++) chk(loads[b], nib(b) >= 4'h6);
        chk(gen_out, 5'h00);
        $display("test start slot done");
        wrap_up();
    end
endmodule

// ==== sim/sequencer_load_model.sv ====
// Far-side loads of the slot sequencer: regulators, switches and output pins.
// Assumes every load bit is a registered enable on core_clk; records slot of each edge.
`timescale 1ns/1ps
module sequencer_load_model (
    // Clock and reset
    input  wire logic              core_clk,
    input  wire logic              reset_n,
    // Sequencer view
    input  wire logic [3:0]        ptr,
    input  wire logic [24:0]       loads,
    // Slot at which each load last switched on and off
    output logic      [24:0][3:0]  rise_slot,
    output logic      [24:0][3:0]  fall_slot
);
    logic [24:0] loads_r;

    // Pointer still holds the slot one edge after the enables move, as each slot spans cycles
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            loads_r <= '0;
        end else begin
            loads_r <= loads;
            for (int i = 0; i < 25; i++) begin
                if (loads[i] && !loads_r[i]) rise_slot[i] <= ptr;
                if (!loads[i] && loads_r[i]) fall_slot[i] <= ptr;
            end
        end
    end
endmodule

// ==== src/power_seq_pkg.sv ====
// Constants and types for the slot configuration bank of the power sequencer.
// Assumes one 10 MHz core clock; register indices are word indices on AXI4-Lite.
package power_seq_pkg;

    // Clock
    localparam int CLK_PERIOD_NS = 100;

    // Slot durations per 4-bit timing code, in ns as printed
    localparam int DUR_NS [16] = '{
        32000,   64000,   96000,   128000,
        160000,  192000,  224000,  256000,
        288000,  384000,  448000,  512000,
        1024000, 2048000, 4096000, 8192000
    };
    localparam int DUR_CYC_DEFAULT [16] = '{
        DUR_NS[0] / CLK_PERIOD_NS,  DUR_NS[1] / CLK_PERIOD_NS,
        DUR_NS[2] / CLK_PERIOD_NS,  DUR_NS[3] / CLK_PERIOD_NS,
        DUR_NS[4] / CLK_PERIOD_NS,  DUR_NS[5] / CLK_PERIOD_NS,
        DUR_NS[6] / CLK_PERIOD_NS,  DUR_NS[7] / CLK_PERIOD_NS,
        DUR_NS[8] / CLK_PERIOD_NS,  DUR_NS[9] / CLK_PERIOD_NS,
        DUR_NS[10] / CLK_PERIOD_NS, DUR_NS[11] / CLK_PERIOD_NS,
        DUR_NS[12] / CLK_PERIOD_NS, DUR_NS[13] / CLK_PERIOD_NS,
        DUR_NS[14] / CLK_PERIOD_NS, DUR_NS[15] / CLK_PERIOD_NS
    };
    localparam int LINEAR_CODE_MAX = 8;
    localparam int CNT_W           = 17;

    // Register word indices (byte address = 4 * index)
    localparam logic [9:0] SEQ_CTRL_IDX               = 10'h081;
    localparam logic [9:0] SLOT_TIMING_CODES_IDX      = 10'h082;
    localparam logic [9:0] LINREG_SLOTS_1_2_IDX       = 10'h083;
    localparam logic [9:0] LINREG_SLOTS_3_4_IDX       = 10'h084;
    localparam logic [9:0] LINREG_SLOTS_5_6_IDX       = 10'h085;
    localparam logic [9:0] LINREG_SLOTS_7_8_IDX       = 10'h086;
    localparam logic [9:0] LINREG_SLOTS_9_10_IDX      = 10'h087;
    localparam logic [9:0] LOW_POWER_DOWN_STATE_LINREG11_IDX     = 10'h088;
    localparam logic [9:0] CORE_BUCK_SLOTS_IDX        = 10'h089;
    localparam logic [9:0] PRO_IO_BUCK_SLOTS_IDX      = 10'h08a;
    localparam logic [9:0] MEM_PERI_BUCK_SLOTS_IDX    = 10'h08b;
    localparam logic [9:0] RAIL_SWITCH_SLOTS_IDX      = 10'h08c;
    localparam logic [9:0] GEN_OUTPUT_EDGE_SLOTS_1_IDX = 10'h08d;
    localparam logic [9:0] GEN_OUTPUT_EDGE_SLOTS_2_IDX = 10'h08e;
    localparam logic [9:0] GEN_OUTPUT_EDGE_SLOTS_3_IDX = 10'h08f;
    localparam logic [9:0] GEN_OUTPUT_EDGE_SLOTS_4_IDX = 10'h090;
    localparam logic [9:0] GEN_OUTPUT_EDGE_SLOTS_5_IDX = 10'h091;
    localparam logic [9:0] BANK_FIRST_IDX = SLOT_TIMING_CODES_IDX;
    localparam logic [9:0] BANK_LAST_IDX  = GEN_OUTPUT_EDGE_SLOTS_5_IDX;

    // Field layout
    localparam int NIB_LO_LSB    = 0;
    localparam int NIB_HI_LSB    = 4;
    localparam int NIB_W         = 4;
    localparam int NUM_TARGETS   = 20;
    localparam int TARGET_NIB0   = 2;
    localparam int NUM_LINREG    = 11;
    localparam int PD_TARGET     = 11;
    localparam int BUCK_A_TARGET = 12;
    localparam int BUCK_B_TARGET = 13;
    localparam int PRO_TARGET    = 14;
    localparam int IO_TARGET     = 15;
    localparam int MEM_TARGET    = 16;
    localparam int PERI_TARGET   = 17;
    localparam int CORE_SW_TARGET = 18;
    localparam int PERI_SW_TARGET = 19;
    localparam int NUM_GPO       = 5;
    localparam int GPO_BANK0     = 11;

    // Slots and reset values
    localparam logic [3:0] SLOT_FIRST  = 4'h0;
    localparam logic [3:0] SLOT_LAST   = 4'hf;
    localparam logic [7:0] BANK_RESET  = 8'h00;
    localparam logic [3:0] START_RESET = 4'h0;

    // AXI4-Lite responses
    localparam logic [1:0] RESP_OKAY   = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    typedef enum logic [2:0] {
        SEQ_IDLE = 3'b001,
        SEQ_UP   = 3'b010,
        SEQ_DOWN = 3'b100
    } seq_state_t;
    localparam int ST_IDLE_BIT = 0;

endpackage

// ==== src/power_seq_slot_config.sv ====
// Slot configuration bank with a slot-stepping sequencer and an AXI4-Lite slave.
// Assumes seq_up_req, seq_down_req and dual_phase_mode come from logic on core_clk.
//
// How it works
// - Lower timing codes 0 to 8 give 32 us plus 32 us per code step, up to 288 us.
// - Lower codes 9 to 13 give 384, 448, 512 us, 1.024 and 2.048 ms, code 15 gives 8.192 ms.
// - The upper nibble holds an idle-slot timing code decoded by the same table.
// - Each of eleven linear regulators has a 4-bit slot, two per byte up to the tenth, and is switched there.
// - The low_power_down_state pause group has its own 4-bit slot in the high nibble.
// - The first core buck has its slot in the low nibble.
// - The second core buck has a slot that is skipped while the core bucks run dual-phase.
// - Processor, memory and peripheral bucks each have their own slot.
// - The I/O buck has its slot in the high nibble beside the processor buck.
// - Core rail switch slot is the low nibble, peripheral rail switch slot the high nibble.
// - Each of five general outputs rises at the slot in the low nibble of its byte, unless its fall slot is the same one.
// - Each of those outputs falls at the slot in the high nibble of its byte.
// - The current slot pointer can be read back and is what the slots compare against.
// - A written start slot is where the next power-up run begins, once.
//
// Added by the designer: the AXI4-Lite slave port.
`timescale 1ns/1ps
module power_seq_slot_config #(
    parameter int DUR_CYC [16] = power_seq_pkg::DUR_CYC_DEFAULT
) (
    // Clock, reset, enable
    input  wire logic        core_clk,
    input  wire logic        reset_n,
    input  wire logic        ce,
    // AXI4-Lite write address
    input  wire logic [11:0] s_axi_awaddr,
    input  wire logic [2:0]  s_axi_awprot,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    // AXI4-Lite write data and response
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // AXI4-Lite read
    input  wire logic [11:0] s_axi_araddr,
    input  wire logic [2:0]  s_axi_arprot,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // Sequencer control
    input  wire logic        seq_up_req,
    input  wire logic        seq_down_req,
    input  wire logic        dual_phase_mode,
    output logic             seq_idle,
    output logic [3:0]       current_slot_pointer,
    // Controlled targets
    output logic [10:0]      linreg_en,
    output logic             pd_group_active,
    output logic             core_buck_a_en,
    output logic             core_buck_b_en,
    output logic             processor_buck_en,
    output logic             io_buck_en,
    output logic             memory_buck_en,
    output logic             peripheral_buck_en,
    output logic             core_rail_switch_en,
    output logic             peripheral_rail_switch_en,
    output logic [4:0]       gen_out
);

    typedef struct packed {
        power_seq_pkg::seq_state_t st;
        logic [3:0]                ptr;
        logic                      act;
        logic [16:0]               cnt;
        logic                      start_pend;
        logic [3:0]                start_slot;
        logic [15:0][7:0]          bank;
        logic [19:0]               en;
        logic [4:0]                gpo;
        logic                      aw_got;
        logic [9:0]                aw_idx;
        logic                      w_got;
        logic [7:0]                wdata;
        logic                      wstb;
        logic                      awready;
        logic                      wready;
        logic                      bvalid;
        logic [1:0]                bresp;
        logic                      arready;
        logic                      rvalid;
        logic [31:0]               rdata;
        logic [1:0]                rresp;
    } state_t;

    state_t s;
    state_t n;

    // Nibble k of the bank; nibble 2*i is the low half of bank byte i
    function automatic logic [3:0] nib(input logic [15:0][7:0] bank, input int k);
        return bank[k / 2][(k % 2) * power_seq_pkg::NIB_W +: power_seq_pkg::NIB_W];
    endfunction

    function automatic logic [3:0] target_slot(input logic [15:0][7:0] bank, input int j);
        return nib(bank, j + power_seq_pkg::TARGET_NIB0);
    endfunction

    function automatic logic [3:0] rise_slot(input logic [15:0][7:0] bank, input int g);
        return bank[power_seq_pkg::GPO_BANK0 + g][power_seq_pkg::NIB_LO_LSB +: 4];
    endfunction

    function automatic logic [3:0] fall_slot(input logic [15:0][7:0] bank, input int g);
        return bank[power_seq_pkg::GPO_BANK0 + g][power_seq_pkg::NIB_HI_LSB +: 4];
    endfunction

    // Whether any target or output edge is assigned to this slot
    function automatic logic occupied(input logic [15:0][7:0] bank, input logic [3:0] p);
        logic hit;
        hit = 1'b0;
        for (int j = 0; j < power_seq_pkg::NUM_TARGETS; j++) begin
            if (target_slot(bank, j) == p) begin
                hit = 1'b1;
            end
        end
        for (int g = 0; g < power_seq_pkg::NUM_GPO; g++) begin
            if (rise_slot(bank, g) == p || fall_slot(bank, g) == p) begin
                hit = 1'b1;
            end
        end
        return hit;
    endfunction

    // Counter load for a timing code: the slot lasts exactly DUR_CYC cycles after the act cycle
    function automatic logic [16:0] dwell(input logic [3:0] code);
        return 17'(DUR_CYC[code] - 1);
    endfunction

    function automatic logic mapped(input logic [9:0] idx);
        return idx >= power_seq_pkg::SEQ_CTRL_IDX && idx <= power_seq_pkg::BANK_LAST_IDX;
    endfunction

    function automatic logic [7:0] read_reg(input state_t st, input logic [9:0] idx);
        logic [7:0] v;
        v = 8'h00;
        if (idx == power_seq_pkg::SEQ_CTRL_IDX) begin
            v = {st.start_slot, st.ptr};
        end else if (mapped(idx)) begin
            v = st.bank[4'(idx - power_seq_pkg::BANK_FIRST_IDX)];
        end
        return v;
    endfunction

    logic [3:0] code_lo;
    logic [3:0] code_hi;
    logic       going_up;

    always_comb begin
        n        = s;
        code_lo  = s.bank[0][power_seq_pkg::NIB_LO_LSB +: 4];
        code_hi  = s.bank[0][power_seq_pkg::NIB_HI_LSB +: 4];
        going_up = (s.st == power_seq_pkg::SEQ_UP);

        // Sequencer
        case (s.st)
            power_seq_pkg::SEQ_IDLE: begin
                if (seq_up_req) begin
                    n.st  = power_seq_pkg::SEQ_UP;
                    n.ptr = s.start_pend ? s.start_slot : power_seq_pkg::SLOT_FIRST;
                    n.start_pend = 1'b0;
                    n.act = 1'b1;
                end else if (seq_down_req) begin
                    n.st  = power_seq_pkg::SEQ_DOWN;
                    n.act = 1'b1;
                end
            end
            power_seq_pkg::SEQ_UP, power_seq_pkg::SEQ_DOWN: begin
                if (s.act) begin
                    n.act = 1'b0;
                    for (int j = 0; j < power_seq_pkg::NUM_TARGETS; j++) begin
                        // Second core buck is left unchanged at its slot in dual-phase mode
                        if (target_slot(s.bank, j) == s.ptr &&
                            !(j == power_seq_pkg::BUCK_B_TARGET && dual_phase_mode)) begin
                            n.en[j] = going_up;
                        end
                    end
                    for (int g = 0; g < power_seq_pkg::NUM_GPO; g++) begin
                        if (rise_slot(s.bank, g) == s.ptr) begin
                            n.gpo[g] = 1'b1;
                        end
                        // Fall wins when both edges share a slot
                        if (fall_slot(s.bank, g) == s.ptr) begin
                            n.gpo[g] = 1'b0;
                        end
                    end
                    // Empty slots use the idle timing code
                    n.cnt = occupied(s.bank, s.ptr) ? dwell(code_lo) : dwell(code_hi);
                end else if (s.cnt != '0) begin
                    n.cnt = s.cnt - 17'(1);
                end else if (going_up ? s.ptr == power_seq_pkg::SLOT_LAST
                                      : s.ptr == power_seq_pkg::SLOT_FIRST) begin
                    n.st = power_seq_pkg::SEQ_IDLE;
                end else begin
                    n.ptr = going_up ? s.ptr + 4'(1) : s.ptr - 4'(1);
                    n.act = 1'b1;
                end
            end
            default: begin
                n.st = power_seq_pkg::SEQ_IDLE;
            end
        endcase

        // Write channel; a bus write of the start slot wins over the clear above
        if (s.awready && s_axi_awvalid) begin
            n.aw_got = 1'b1;
            n.aw_idx = s_axi_awaddr[11:2];
        end
        if (s.wready && s_axi_wvalid) begin
            n.w_got = 1'b1;
            n.wdata = s_axi_wdata[7:0];
            n.wstb  = s_axi_wstrb[0];
        end
        if (s.bvalid && s_axi_bready) begin
            n.bvalid = 1'b0;
        end
        if (s.aw_got && s.w_got && !s.bvalid) begin
            n.aw_got = 1'b0;
            n.w_got  = 1'b0;
            n.bvalid = 1'b1;
            n.bresp  = mapped(s.aw_idx) ? power_seq_pkg::RESP_OKAY : power_seq_pkg::RESP_SLVERR;
            if (s.wstb && s.aw_idx == power_seq_pkg::SEQ_CTRL_IDX) begin
                n.start_slot = s.wdata[power_seq_pkg::NIB_HI_LSB +: 4];
                n.start_pend = 1'b1;
            end else if (s.wstb && mapped(s.aw_idx)) begin
                n.bank[4'(s.aw_idx - power_seq_pkg::BANK_FIRST_IDX)] = s.wdata;
            end
        end

        // Read channel
        if (s.rvalid && s_axi_rready) begin
            n.rvalid = 1'b0;
        end
        if (s.arready && s_axi_arvalid) begin
            n.rvalid = 1'b1;
            n.rdata  = {24'h00_0000, read_reg(s, s_axi_araddr[11:2])};
            n.rresp  = mapped(s_axi_araddr[11:2]) ? power_seq_pkg::RESP_OKAY
                                                  : power_seq_pkg::RESP_SLVERR;
        end

        // One transaction per direction in flight
        n.awready = !n.aw_got && !n.bvalid;
        n.wready  = !n.w_got && !n.bvalid;
        n.arready = !n.rvalid;
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            s            <= '0;
            s.st         <= power_seq_pkg::SEQ_IDLE;
            s.ptr        <= power_seq_pkg::SLOT_FIRST;
            s.start_slot <= power_seq_pkg::START_RESET;
            s.bank       <= {16{power_seq_pkg::BANK_RESET}};
        end else if (ce) begin
            s <= n;
        end
    end

    // Outputs straight from the state register
    assign s_axi_awready = s.awready;
    assign s_axi_wready  = s.wready;
    assign s_axi_bresp   = s.bresp;
    assign s_axi_bvalid  = s.bvalid;
    assign s_axi_arready = s.arready;
    assign s_axi_rdata   = s.rdata;
    assign s_axi_rresp   = s.rresp;
    assign s_axi_rvalid  = s.rvalid;
    assign seq_idle      = s.st[power_seq_pkg::ST_IDLE_BIT];
    assign current_slot_pointer      = s.ptr;
    assign linreg_en                 = s.en[power_seq_pkg::NUM_LINREG-1:0];
    assign pd_group_active           = s.en[power_seq_pkg::PD_TARGET];
    assign core_buck_a_en            = s.en[power_seq_pkg::BUCK_A_TARGET];
    assign core_buck_b_en            = s.en[power_seq_pkg::BUCK_B_TARGET];
    assign processor_buck_en         = s.en[power_seq_pkg::PRO_TARGET];
    assign io_buck_en                = s.en[power_seq_pkg::IO_TARGET];
    assign memory_buck_en            = s.en[power_seq_pkg::MEM_TARGET];
    assign peripheral_buck_en        = s.en[power_seq_pkg::PERI_TARGET];
    assign core_rail_switch_en       = s.en[power_seq_pkg::CORE_SW_TARGET];
    assign peripheral_rail_switch_en = s.en[power_seq_pkg::PERI_SW_TARGET];
    assign gen_out                   = s.gpo;

    // Checks
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!reset_n);

    sequence up_start_pending;
        ce && s.st == power_seq_pkg::SEQ_IDLE && seq_up_req && s.start_pend;
    endsequence

    sequence slot_act(logic up);
        ce && s.act && (s.st == power_seq_pkg::SEQ_UP) == up && s.st != power_seq_pkg::SEQ_IDLE;
    endsequence

    sequence slot_expires;
        ce && !s.act && s.cnt == '0 && s.st != power_seq_pkg::SEQ_IDLE;
    endsequence

    a_linear_dwell: assert property (
        slot_act(1'b1) and (ce && occupied(s.bank, s.ptr) && code_lo <= 4'(power_seq_pkg::LINEAR_CODE_MAX))
        |=> s.cnt == 17'((32'($past(code_lo)) + 1) * DUR_CYC[0] - 1))
        else $error("linear slot dwell wrong");

    a_long_dwell: assert property (
        (ce && s.act && s.st != power_seq_pkg::SEQ_IDLE && occupied(s.bank, s.ptr) && code_lo == 4'hf)
        |=> s.cnt == 17'(DUR_CYC[15] - 1))
        else $error("longest slot dwell wrong");

    a_idle_dwell: assert property (
        (ce && s.act && s.st != power_seq_pkg::SEQ_IDLE && !occupied(s.bank, s.ptr))
        |=> s.cnt == 17'(DUR_CYC[$past(code_hi)] - 1))
        else $error("idle slot dwell wrong");

    a_linreg_on_up: assert property (
        slot_act(1'b1) and (target_slot(s.bank, 0) == s.ptr) |=> linreg_en[0])
        else $error("regulator not enabled at its slot");

    a_pd_off_down: assert property (
        slot_act(1'b0) and (target_slot(s.bank, power_seq_pkg::PD_TARGET) == s.ptr)
        |=> !pd_group_active)
        else $error("low_power_down_state group not paused at its slot");

    a_dual_skip_b: assert property (
        (ce && s.act && dual_phase_mode) |=> $stable(core_buck_b_en))
        else $error("second core buck moved in dual-phase mode");

    a_gpo_edges: assert property (
        (ce && s.act && s.st != power_seq_pkg::SEQ_IDLE && rise_slot(s.bank, 0) == s.ptr
         && fall_slot(s.bank, 0) != s.ptr) |=> gen_out[0])
        else $error("output not raised at rise slot");

    a_gpo_fall: assert property (
        (ce && s.act && s.st != power_seq_pkg::SEQ_IDLE && fall_slot(s.bank, 4) == s.ptr)
        |=> !gen_out[4])
        else $error("output not lowered at fall slot");

    a_ptr_readback: assert property (
        (ce && s.arready && s_axi_arvalid && s_axi_araddr[11:2] == power_seq_pkg::SEQ_CTRL_IDX)
        |=> s_axi_rvalid && s_axi_rdata[3:0] == $past(s.ptr))
        else $error("pointer readback wrong");

    a_start_slot: assert property (
        up_start_pending |=> current_slot_pointer == $past(s.start_slot) && !s.start_pend)
        else $error("run did not begin at written start slot");

    a_pointer_step: assert property (
        slot_expires and (ce && s.ptr != power_seq_pkg::SLOT_LAST && s.st == power_seq_pkg::SEQ_UP)
        |=> s.act && current_slot_pointer == $past(s.ptr) + 4'(1))
        else $error("pointer did not advance after slot expiry");

    a_down_step: assert property (
        slot_expires and (ce && s.ptr != power_seq_pkg::SLOT_FIRST
                          && s.st == power_seq_pkg::SEQ_DOWN)
        |=> s.act && current_slot_pointer == $past(s.ptr) - 4'(1))
        else $error("pointer did not step down after slot expiry");

    a_write_answer: assert property (
        (ce && s.aw_got && s.w_got && !s.bvalid) |=> s_axi_bvalid [*1] ##0 !s_axi_awready)
        else $error("write not answered");

    a_read_answer: assert property (
        (ce && s.arready && s_axi_arvalid) |=> s_axi_rvalid && !s_axi_arready)
        else $error("read not answered");

endmodule
